/* File: rtl/cxi_core.v */
`timescale 1ns/1ps
`include "cxi_defines.vh"
// How it works
// - bit test branch: bit set clears it and takes short branch, else falls through
// - bit test branch leaves the program status word untouched
// - three-bit index picks bit 0 to 7 of the addressed byte
// - special register operand is one 8-bit location
// - short target is end of instruction plus signed -128..+127
// - bank return only valid after bank call entry, refused otherwise (including after task switch)
// - end of interrupt pulses a notify to the interrupt controller
// - stop instruction enters and holds the stop state
// - bank call selects bank, jumps to its segment and vector counter
// - task switch selects bank, jumps to its segment and saved counter
// - copy stack segment and pointer from prior bank into current bank
// - write current stack segment and pointer into operand-selected bank
// - io op with io break flag clear traps instead of executing
// - float escape op always traps instead of executing
// - four-bit immediate accepts only 0 to F
// - translate index is the low accumulator byte into 256-byte table
// - return discard count spans 0 to 64K, added to stack pointer
module cxi_core (
	clk,
	rst_n,
	op_valid,
	op_code,
	op_reg16,
	op_bit_index,
	op_disp8,
	op_next_pc,
	op_imm,
	sfr_rdata,
	psw_in,
	acc_in,
	op_ready,
	sfr_we,
	sfr_wdata,
	branch_taken,
	branch_seg,
	branch_pc,
	bank_sel,
	stack_seg,
	stack_ptr,
	eoi_notify,
	trap_valid,
	trap_cause,
	stop_state,
	psw_we,
	trans_index,
	imm_error,
	bad_return
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire        op_valid;
	input  wire [3:0]  op_code;
	input  wire [15:0] op_reg16;
	input  wire [2:0]  op_bit_index;
	input  wire [7:0]  op_disp8;
	input  wire [15:0] op_next_pc;
	input  wire [16:0] op_imm;
	input  wire [7:0]  sfr_rdata;
	input  wire [15:0] psw_in;
	input  wire [15:0] acc_in;
	output reg         op_ready;
	output reg         sfr_we;
	output reg  [7:0]  sfr_wdata;
	output reg         branch_taken;
	output reg  [15:0] branch_seg;
	output reg  [15:0] branch_pc;
	output reg  [2:0]  bank_sel;
	output reg  [15:0] stack_seg;
	output reg  [15:0] stack_ptr;
	output reg         eoi_notify;
	output reg         trap_valid;
	output reg  [1:0]  trap_cause;
	output reg         stop_state;
	output reg         psw_we;
	output reg  [7:0]  trans_index;
	output reg         imm_error;
	output reg         bad_return;

	// =======================================================================
	// states
	localparam ST_IDLE  = 3'h0;
	localparam ST_RD0   = 3'h1;
	localparam ST_RD1   = 3'h2;
	localparam ST_DONE  = 3'h3;
	localparam ST_STOP  = 3'h4;

	reg [2:0]  state;
	reg [3:0]  cur_op;
	reg [2:0]  tgt_bank;
	reg [2:0]  prior_bank;
	reg        bank_entered;
	reg [15:0] word0;
	reg        mem_we;
	reg [5:0]  mem_waddr;
	reg [15:0] mem_wdata;
	reg [5:0]  mem_raddr;
	wire [15:0] mem_rdata;
	wire [15:0] short_target;

	// =======================================================================
	// helpers
	function [5:0] slot_addr;
		input [2:0] bank;
		input [1:0] slot;
		input       hi;
		begin
			slot_addr = {hi, bank, slot};
		end
	endfunction

	function [2:0] bank_of;
		input [15:0] r;
		begin
			bank_of = r[`CXI_BANK_MSB:`CXI_BANK_LSB];
		end
	endfunction

	function is_switch;
		input [3:0] op;
		begin
			is_switch = (op == `CXI_OP_BANK_CALL) || (op == `CXI_OP_TASK_SW);
		end
	endfunction

	// =======================================================================
	// bank store and short target adder
	cxi_bank_mem #(.AW(6), .DW(16)) u_mem (
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	cxi_branch_calc u_br (
		.next_pc (op_next_pc),
		.disp8   (op_disp8),
		.target  (short_target)
	);

	// =======================================================================
	// sequencer
	always @(posedge clk) begin
		if (!rst_n) begin
			state        <= ST_IDLE;
			cur_op       <= `CXI_OP_NONE;
			tgt_bank     <= `CXI_RESET_BANK;
			prior_bank   <= `CXI_RESET_BANK;
			bank_entered <= 1'b0;
			word0        <= 16'h0000;
			mem_we       <= 1'b0;
			mem_waddr    <= 6'h00;
			mem_wdata    <= 16'h0000;
			mem_raddr    <= 6'h00;
			op_ready     <= 1'b0;
			sfr_we       <= 1'b0;
			sfr_wdata    <= 8'h00;
			branch_taken <= 1'b0;
			branch_seg   <= 16'h0000;
			branch_pc    <= 16'h0000;
			bank_sel     <= `CXI_RESET_BANK;
			stack_seg    <= 16'h0000;
			stack_ptr    <= 16'h0000;
			eoi_notify   <= 1'b0;
			trap_valid   <= 1'b0;
			trap_cause   <= `CXI_TRAP_NONE;
			stop_state   <= 1'b0;
			psw_we       <= 1'b0;
			trans_index  <= 8'h00;
			imm_error    <= 1'b0;
			bad_return   <= 1'b0;
		end else begin
			// one-cycle pulses default low
			op_ready     <= 1'b0;
			sfr_we       <= 1'b0;
			branch_taken <= 1'b0;
			eoi_notify   <= 1'b0;
			trap_valid   <= 1'b0;
			mem_we       <= 1'b0;
			imm_error    <= 1'b0;
			bad_return   <= 1'b0;
			psw_we       <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (op_valid) begin
					cur_op   <= op_code;
					tgt_bank <= bank_of(op_reg16);
					state    <= ST_DONE;
					op_ready <= 1'b1;
					case (op_code)
					`CXI_OP_BIT_TEST_CLEAR_BRANCH_BR: begin
						// sfr_rdata is the one 8-bit location addressed
						if (sfr_rdata[op_bit_index]) begin
							sfr_we       <= 1'b1;
							sfr_wdata    <= sfr_rdata & ~(8'h01 << op_bit_index);
							branch_taken <= 1'b1;
							branch_seg   <= 16'h0000;
							branch_pc    <= short_target;
						end
					end
					`CXI_OP_EOI: begin
						eoi_notify <= 1'b1;
					end
					`CXI_OP_STOP: begin
						stop_state <= 1'b1;
						state      <= ST_STOP;
					end
					`CXI_OP_IO: begin
						// primitive block io arrives on this same code
						if (!psw_in[`CXI_IOBRK_BIT]) begin
							trap_valid <= 1'b1;
							trap_cause <= `CXI_TRAP_IO;
						end
					end
					`CXI_OP_FLOAT: begin
						// no coprocessor sits behind this core, so every escape traps
						trap_valid <= 1'b1;
						trap_cause <= `CXI_TRAP_FLOAT;
					end
					`CXI_OP_TRANS: begin
						// only the low byte indexes; the table base lives elsewhere
						trans_index <= acc_in[7:0];
					end
					`CXI_OP_RET_DISC: begin
						// 17-bit count reaches 64K; wraps in the 16-bit pointer
						stack_ptr <= stack_ptr + op_imm[15:0];
					end
					`CXI_OP_IMM4: begin
						imm_error <= (op_imm > {9'h000, `CXI_IMM4_MAX});
					end
					`CXI_OP_BANK_RET: begin
						if (bank_entered) begin
							bank_sel     <= prior_bank;
							bank_entered <= 1'b0;
							mem_raddr    <= slot_addr(prior_bank, `CXI_SLOT_PS, 1'b0);
							op_ready     <= 1'b0;
							state        <= ST_RD0;
						end else begin
							// an entry not made by bank call (task switch or none) must leave by the ordinary return
							bad_return <= 1'b1;
						end
					end
					`CXI_OP_BANK_CALL, `CXI_OP_TASK_SW: begin
						prior_bank   <= bank_sel;
						bank_sel     <= bank_of(op_reg16);
						bank_entered <= (op_code == `CXI_OP_BANK_CALL);
						mem_raddr    <= slot_addr(bank_of(op_reg16), `CXI_SLOT_PS, 1'b0);
						// park the outgoing stack pair so a later copy can fetch it
						mem_we       <= 1'b1;
						mem_waddr    <= slot_addr(bank_sel, `CXI_SLOT_SS, 1'b0);
						mem_wdata    <= stack_seg;
						op_ready     <= 1'b0;
						state        <= ST_RD0;
					end
					`CXI_OP_SP_FROM: begin
						mem_raddr <= slot_addr(prior_bank, `CXI_SLOT_SS, 1'b0);
						op_ready  <= 1'b0;
						state     <= ST_RD0;
					end
					`CXI_OP_SP_TO: begin
						mem_we    <= 1'b1;
						mem_waddr <= slot_addr(bank_of(op_reg16), `CXI_SLOT_SS, 1'b0);
						mem_wdata <= stack_seg;
						word0     <= stack_ptr;
						op_ready  <= 1'b0;
						state     <= ST_RD1;
					end
					default: begin
					end
					endcase
				end
			end
			ST_RD0: begin
				// read latency of the bank memory is one cycle
				state <= ST_RD1;
				if (is_switch(cur_op)) begin
					// second half of the outgoing pair; prior_bank already names the old bank
					mem_we    <= 1'b1;
					mem_waddr <= slot_addr(prior_bank, `CXI_SLOT_SP, 1'b1);
					mem_wdata <= stack_ptr;
				end
				case (cur_op)
				`CXI_OP_BANK_CALL: mem_raddr <= slot_addr(tgt_bank, `CXI_SLOT_VPC, 1'b0);
				`CXI_OP_TASK_SW:   mem_raddr <= slot_addr(tgt_bank, `CXI_SLOT_SAVEPC, 1'b0);
				`CXI_OP_BANK_RET:  mem_raddr <= slot_addr(prior_bank, `CXI_SLOT_SAVEPC, 1'b0);
				default:           mem_raddr <= slot_addr(prior_bank, `CXI_SLOT_SP, 1'b1);
				endcase
			end
			ST_RD1: begin
				state    <= ST_DONE;
				op_ready <= 1'b1;
				case (cur_op)
				`CXI_OP_SP_TO: begin
					mem_we    <= 1'b1;
					// pointer half of the pair; the segment half went out on entry
					mem_waddr <= slot_addr(tgt_bank, `CXI_SLOT_SP, 1'b1);
					mem_wdata <= word0;
				end
				`CXI_OP_SP_FROM: begin
					word0    <= mem_rdata;
					op_ready <= 1'b0;
					state    <= ST_DONE;
				end
				default: begin
					word0    <= mem_rdata;
					op_ready <= 1'b0;
					state    <= ST_DONE;
				end
				endcase
			end
			ST_DONE: begin
				state <= ST_IDLE;
				if (!op_ready) begin
					op_ready <= 1'b1;
					case (cur_op)
					`CXI_OP_SP_FROM: begin
						stack_seg <= word0;
						stack_ptr <= mem_rdata;
					end
					default: begin
						branch_taken <= 1'b1;
						branch_seg   <= word0;
						branch_pc    <= mem_rdata;
					end
					endcase
				end
			end
			ST_STOP: begin
				// only reset leaves the stop state in this block
				stop_state <= 1'b1;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // cxi_core

/* File: inc/cxi_defines.vh */
`ifndef CXI_DEFINES_VH
`define CXI_DEFINES_VH
// ===========================================================================
// operation codes presented on op_code
`define CXI_OP_NONE        4'h0
`define CXI_OP_BIT_TEST_CLEAR_BRANCH_BR    4'h1
`define CXI_OP_BANK_RET    4'h2
`define CXI_OP_EOI         4'h3
`define CXI_OP_STOP        4'h4
`define CXI_OP_BANK_CALL   4'h5
`define CXI_OP_TASK_SW     4'h6
`define CXI_OP_SP_FROM     4'h7
`define CXI_OP_SP_TO       4'h8
`define CXI_OP_IO          4'h9
`define CXI_OP_FLOAT       4'hA
`define CXI_OP_TRANS       4'hB
`define CXI_OP_RET_DISC    4'hC
`define CXI_OP_IMM4        4'hD
// ===========================================================================
// field positions and widths
`define CXI_BANK_LSB       0
`define CXI_BANK_MSB       2
`define CXI_BIT_MSB        2
`define CXI_IOBRK_BIT      1
`define CXI_IMM4_MAX       8'h0F
// ===========================================================================
// trap causes
`define CXI_TRAP_NONE      2'h0
`define CXI_TRAP_IO        2'h1
`define CXI_TRAP_FLOAT     2'h2
// ===========================================================================
// bank save-area slots
`define CXI_SLOT_PS        2'h0
`define CXI_SLOT_VPC       2'h1
`define CXI_SLOT_SAVEPC    2'h2
`define CXI_SLOT_SS        2'h3
`define CXI_SLOT_SP        2'h0
`define CXI_RESET_BANK     3'h0
`endif

/* File: rtl/cxi_bank_mem.v */
`timescale 1ns/1ps
`include "cxi_defines.vh"
// ===========================================================================
// bank storage: one word per (bank, slot); registered read data
module cxi_bank_mem #(
	parameter AW = 6,
	parameter DW = 16
) (
	clk,
	we,
	waddr,
	wdata,
	raddr,
	rdata
);
	input  wire          clk;
	input  wire          we;
	input  wire [AW-1:0] waddr;
	input  wire [DW-1:0] wdata;
	input  wire [AW-1:0] raddr;
	output reg  [DW-1:0] rdata;

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // cxi_bank_mem

/* File: rtl/cxi_branch_calc.v */
`timescale 1ns/1ps
`include "cxi_defines.vh"
// ===========================================================================
// short branch target: end of instruction plus signed 8-bit displacement
module cxi_branch_calc (
	next_pc,
	disp8,
	target
);
	input  wire [15:0] next_pc;
	input  wire [7:0]  disp8;
	output wire [15:0] target;

	assign target = next_pc + {{8{disp8[7]}}, disp8};
endmodule // cxi_branch_calc

/* File: tb/cxi_core_checker.sv */
`timescale 1ns/1ps
`include "cxi_defines.vh"
module cxi_core_checker (
	input logic        clk,
	input logic        rst_n,
	input logic        op_valid,
	input logic [3:0]  op_code,
	input logic [15:0] op_reg16,
	input logic [2:0]  op_bit_index,
	input logic [7:0]  op_disp8,
	input logic [15:0] op_next_pc,
	input logic [16:0] op_imm,
	input logic [7:0]  sfr_rdata,
	input logic [15:0] psw_in,
	input logic        op_ready,
	input logic        sfr_we,
	input logic [7:0]  sfr_wdata,
	input logic        branch_taken,
	input logic [15:0] branch_pc,
	input logic [2:0]  bank_sel,
	input logic        eoi_notify,
	input logic        trap_valid,
	input logic [1:0]  trap_cause,
	input logic        stop_state,
	input logic        psw_we,
	input logic        imm_error,
	input logic        bad_return
);
	// ==========
	// operands stay held until op_ready, so they are read at the ready cycle
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_call;
		op_ready && op_code == `CXI_OP_BANK_CALL;
	endsequence
	AST_BIT_TEST_CLEAR_BRANCH_CLEAR: assert property (sfr_we |-> op_code == `CXI_OP_BIT_TEST_CLEAR_BRANCH_BR && op_ready
		&& sfr_wdata == (sfr_rdata & ~(8'h01 << op_bit_index))) else $error("bit clear value wrong");
	AST_BIT_TEST_CLEAR_BRANCH_TARGET: assert property (branch_taken && op_code == `CXI_OP_BIT_TEST_CLEAR_BRANCH_BR
		|-> branch_pc == op_next_pc + {{8{op_disp8[7]}}, op_disp8}) else $error("short target wrong");
	AST_PSW_KEPT: assert property (!psw_we) else $error("status word written");
	AST_IO_TRAP: assert property (op_ready && op_code == `CXI_OP_IO
		|-> trap_valid == !psw_in[1] && (psw_in[1] || trap_cause == 2'h1)) else $error("io trap wrong");
	AST_FLOAT_TRAP: assert property (op_ready && op_code == `CXI_OP_FLOAT
		|-> trap_valid && trap_cause == 2'h2) else $error("float trap wrong");
	AST_EOI: assert property (eoi_notify |-> op_ready && op_code == `CXI_OP_EOI) else $error("stray notify");
	AST_STOP_STICKY: assert property (stop_state |=> stop_state && !op_ready) else $error("stop left");
	AST_IMM_RANGE: assert property (op_ready && op_code == `CXI_OP_IMM4
		|-> imm_error == (op_imm > 17'h0000F)) else $error("imm range wrong");
	AST_CALL_BANK: assert property (s_call |-> branch_taken && bank_sel == op_reg16[2:0])
		else $error("call bank wrong");
	AST_BAD_RETURN: assert property (bad_return |-> op_ready && op_code == `CXI_OP_BANK_RET)
		else $error("stray bad return");
endmodule // cxi_core_checker
bind cxi_core cxi_core_checker u_chk (.*);

/* File: tb/cxi_core_partner.sv */
`timescale 1ns/1ps
// ==========
// one sfr byte and an end-of-interrupt counter
module cxi_core_partner (
	input  wire       clk,
	input  wire       ld,
	input  wire [7:0] ld_val,
	input  wire       sfr_we,
	input  wire [7:0] sfr_wdata,
	input  wire       eoi_notify,
	output reg  [7:0] sfr_rdata,
	output reg  [7:0] eoi_count
);
	initial begin
		sfr_rdata = 8'h00;
		eoi_count = 8'h00;
	end
	always @(posedge clk) begin
		if (ld)
			sfr_rdata <= ld_val;
		else if (sfr_we)
			sfr_rdata <= sfr_wdata;
		if (eoi_notify)
			eoi_count <= eoi_count + 8'h01;
	end
endmodule // cxi_core_partner

/* File: tb/cxi_core_tb_top.sv */
`timescale 1ns/1ps
`include "cxi_defines.vh"
module cxi_core_tb_top;
	// ==========
	// signals
	reg clk = 0, rst_n = 0, op_valid = 0, ld = 0, pf;
	reg [3:0] op_code = 0;
	reg [15:0] op_reg16 = 0, psw_in = 0, acc_in = 0, op_next_pc = 16'h1000;
	reg [2:0] op_bit_index = 0;
	reg [7:0] op_disp8 = 0, ld_val = 0;
	reg [16:0] op_imm = 0;
	wire op_ready, sfr_we, branch_taken, eoi_notify, trap_valid, stop_state, psw_we, imm_error, bad_return;
	wire [7:0] sfr_rdata, sfr_wdata, trans_index, eoi_count;
	wire [15:0] branch_seg, branch_pc, stack_seg, stack_ptr;
	wire [2:0] bank_sel;
	wire [1:0] trap_cause;
	integer n_fail = 0, checked = 0, i, lat;
	reg [5:0] got;
	reg [3:0] c;
	reg [6:0] ex;
	reg [47:0] rows [0:8];
	always #10 clk = ~clk;
	cxi_core u_dut (.*);
	cxi_core_partner u_mem (.clk(clk), .ld(ld), .ld_val(ld_val), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
		.eoi_notify(eoi_notify), .sfr_rdata(sfr_rdata), .eoi_count(eoi_count));
	// ==========
	// tasks
	task chk(input [127:0] nm, input [31:0] s, input [31:0] e);
		begin
			checked = checked + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("wrong value %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// a one-cycle gap before each op keeps every input to one change per step
	task do_op(input [3:0] k);
		begin
			@(posedge clk);
			#1 ld = 0;
			op_code = k;
			op_valid = 1;
			lat = 0;
			do begin
				@(posedge clk);
				#1 lat = lat + 1;
			end while (op_ready !== 1'b1 && lat < 12);
			got = {branch_taken, sfr_we, eoi_notify, trap_valid, imm_error, bad_return};
			// drop at once: a four-cycle op is idle again on its ready edge
			op_valid = 0;
			@(posedge clk);
			#1;
		end
	endtask
	task end_of_test;
		begin
			$display("checked %0d n_fail %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		#400000 n_fail = n_fail + 1;
		end_of_test;
	end
	// ==========
	// tests
	initial begin
		rows[0] = {`CXI_OP_BIT_TEST_CLEAR_BRANCH_BR, 3'h3, 8'h08, 1'h0, 17'h0, 8'h05, 7'h60};
		rows[1] = {`CXI_OP_BIT_TEST_CLEAR_BRANCH_BR, 3'h7, 8'h7F, 1'h0, 17'h0, 8'h05, 7'h00};
		rows[2] = {`CXI_OP_BIT_TEST_CLEAR_BRANCH_BR, 3'h0, 8'hFF, 1'h0, 17'h0, 8'h80, 7'h60};
		rows[3] = {`CXI_OP_EOI, 3'h0, 8'h00, 1'h0, 17'h0, 8'h00, 7'h10};
		rows[4] = {`CXI_OP_IO, 3'h0, 8'h00, 1'h0, 17'h0, 8'h00, 7'h09};
		rows[5] = {`CXI_OP_IO, 3'h0, 8'h00, 1'h1, 17'h0, 8'h00, 7'h00};
		rows[6] = {`CXI_OP_FLOAT, 3'h0, 8'h00, 1'h1, 17'h0, 8'h00, 7'h0A};
		rows[7] = {`CXI_OP_IMM4, 3'h0, 8'h00, 1'h0, 17'hF, 8'h00, 7'h00};
		rows[8] = {`CXI_OP_IMM4, 3'h0, 8'h00, 1'h0, 17'h10, 8'h00, 7'h04};
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		chk("reset", {op_ready, stop_state, bank_sel, stack_ptr}, 0);
		for (i = 0; i < 9; i = i + 1) begin
			{c, op_bit_index, ld_val, pf, op_imm, op_disp8, ex} = rows[i];
			psw_in = {14'h0000, pf, 1'h0};
			ld = 1;
			do_op(c);
			chk("flags", got[5:1], ex[6:2]);
			chk("latency", lat, 1);
			if (ex[3]) chk("cause", trap_cause, ex[1:0]);
			if (ex[6]) chk("target", branch_pc, {16'h1000 + {{8{op_disp8[7]}}, op_disp8}});
			if (ex[5]) chk("sfr", sfr_rdata, ld_val & ~(8'h01 << op_bit_index));
			if (!ex[5]) chk("sfr kept", sfr_rdata, ld_val);
			$display("row %0d done", i);
		end
		chk("notify count", eoi_count, 8'h01);
		acc_in = 16'h12AB;
		do_op(`CXI_OP_TRANS);
		chk("table index", trans_index, 8'hAB);
		op_reg16 = 16'hFFFD;
		do_op(`CXI_OP_BANK_CALL);
		chk("call", {lat[3:0], bank_sel, got[5]}, {4'h4, 3'h5, 1'h1});
		do_op(`CXI_OP_BANK_RET);
		chk("return", {bank_sel, got[0]}, 4'h0);
		do_op(`CXI_OP_BANK_RET);
		chk("bad return", got[0], 1);
		$display("bank test done");
		op_imm = 17'h00006;
		do_op(`CXI_OP_RET_DISC);
		op_imm = 17'h10000;
		do_op(`CXI_OP_RET_DISC);
		chk("discard", stack_ptr, 16'h0006);
		op_reg16 = 16'hFF0A;
		do_op(`CXI_OP_BANK_CALL);
		chk("call two", {bank_sel, stack_ptr}, {3'h2, 16'h0006});
		op_imm = 17'h00010;
		do_op(`CXI_OP_RET_DISC);
		do_op(`CXI_OP_SP_FROM);
		chk("prior sp", {lat[3:0], stack_ptr}, {4'h4, 16'h0006});
		chk("prior ss", stack_seg, 16'h0000);
		do_op(`CXI_OP_RET_DISC);
		op_reg16 = 16'hFFF8;
		do_op(`CXI_OP_SP_TO);
		chk("copy latency", lat, 2);
		do_op(`CXI_OP_RET_DISC);
		do_op(`CXI_OP_SP_FROM);
		chk("copied sp", stack_ptr, 16'h0016);
		op_reg16 = 16'h0003;
		do_op(`CXI_OP_TASK_SW);
		chk("task", {lat[3:0], bank_sel, got[5]}, {4'h4, 3'h3, 1'h1});
		$display("stack test done");
		do_op(`CXI_OP_STOP);
		chk("stop", stop_state, 1);
		do_op(`CXI_OP_EOI);
		chk("ignored", {lat[3:0], eoi_count}, {4'hC, 8'h01});
		rst_n = 0;
		repeat (2) @(posedge clk);
		#1 chk("stop cleared", {stop_state, bank_sel}, 0);
		rst_n = 1;
		do_op(`CXI_OP_EOI);
		chk("after reset", {lat[3:0], eoi_count}, {4'h1, 8'h02});
		$display("stop test done");
		end_of_test;
	end
endmodule // cxi_core_tb_top
